// ==== ssac_pkg.sv ====
package ssac_pkg;

    // Array organisation: four lanes of eight data bits plus one parity bit
    localparam int LANES      = 4;
    localparam int BYTE_W     = 8;
    localparam int LANE_W     = 9;
    localparam int DATA_W     = 32;
    localparam int WORD_W     = 36;
    localparam int ADDR_W     = 19;
    // Storage kept small; only the low address bits index it
    localparam int ARRAY_AW   = 6;
    localparam int DEPTH      = 64;
    localparam int BURST_W    = 2;

    // AXI4-Lite register map
    localparam logic [31:0] CTRL_OFS   = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Control register fields
    localparam int          CTRL_LINEAR_BIT = 0;
    localparam logic        CTRL_LINEAR_RST = 1'b0;

    // Status register fields
    localparam int STAT_KIND_LSB  = 0;
    localparam int STAT_LO_LSB    = 2;
    localparam int STAT_CNT_LSB   = 4;
    localparam int STAT_QVAL_BIT  = 6;
    localparam int STAT_SLEEP_BIT = 7;

    typedef enum logic [1:0] {
        CYC_DESEL = 2'b00,
        CYC_READ  = 2'b01,
        CYC_WRITE = 2'b10,
        CYC_SLEEP = 2'b11
    } ssac_cyc_t;

endpackage

// ==== ssac_top.sv ====
// Operation
// - Deselect on bad chip selects with a strobe low; data pins released.
// - Sleep request overrides all controls and releases data and parity pins.
// - Processor strobe with chips selected begins a read at external address.
// - Controller strobe alone begins a burst; write if write term active.
// - No strobe, step low: read at next burst address when not writing.
// - No strobe, step low, write term active: write next burst address.
// - No strobe, step high: stay at current address, read or write.
// - Write term active on global write or byte enable with a lane.
// - Read when global write high and no byte lane enabled.
// - Byte writes change only enabled lanes, data and parity bits.
// - Output drive applied combinationally with cycle type, never clocked.
// - Write cycles mask output drive; data pins stay released.
// - Read cycle with output drive high releases all data bits.
// - Selected read cycle with output drive low drives all data bits; here only when the previous cycle was also a read.
// - Processor strobe edge with chips selected starts a read, write inputs ignored.
// - Output drive disregarded for all remaining beats of a write.
// - Two-bit burst counter, interleaved or linear, from low address bits.
// - Read data passes an output register, appears after next edge.
// - Processor-strobe write completes at second edge with controls and data.
// - First cycle after deselect keeps outputs released regardless of drive.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module ssac_top
    import ssac_pkg::*;
(
    // Clock and reset
    input  wire logic                         clock,
    input  wire logic                         rstn,
    // Memory bus control
    input  wire logic [ssac_pkg::ADDR_W-1:0]  addr,
    input  wire logic                         chip_select_1_n,
    input  wire logic                         chip_select_2,
    input  wire logic                         chip_select_3_n,
    input  wire logic                         sleep_request,
    input  wire logic                         processor_addr_strobe_n,
    input  wire logic                         controller_addr_strobe_n,
    input  wire logic                         burst_step_n,
    input  wire logic                         global_write_n,
    input  wire logic                         byte_write_enable_n,
    input  wire logic [ssac_pkg::LANES-1:0]   lane_write_n,
    input  wire logic                         output_drive_n,
    // Data and parity pins
    input  wire logic [ssac_pkg::DATA_W-1:0]  dq_in,
    output logic      [ssac_pkg::DATA_W-1:0]  dq_out,
    output logic                              dq_oe,
    input  wire logic [ssac_pkg::LANES-1:0]   parity_in,
    output logic      [ssac_pkg::LANES-1:0]   parity_out,
    output logic                              parity_oe,
    // AXI4-Lite write channels
    input  wire logic [31:0]                  s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [31:0]                  s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready
);
    import ssac_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][WORD_W-1:0] mem;
        ssac_cyc_t                    kind;
        logic                         linear;
        logic [ARRAY_AW-3:0]          base_hi;
        logic [BURST_W-1:0]           base_lo;
        logic [BURST_W-1:0]           cnt;
        logic [WORD_W-1:0]            sel_data;
        logic [WORD_W-1:0]            q;
        logic                         q_valid;
        logic                         aw_have;
        logic [31:0]                  aw_addr;
        logic                         w_have;
        logic [31:0]                  w_data;
        logic [3:0]                   w_strb;
        logic                         awready;
        logic                         wready;
        logic                         bvalid;
        logic [1:0]                   bresp;
        logic                         arready;
        logic                         rvalid;
        logic [31:0]                  rdata;
        logic [1:0]                   rresp;
    } ssac_state_t;

    ssac_state_t st_r;
    ssac_state_t st_nxt;

    logic                sel_ok;
    logic                write_term;
    logic [LANES-1:0]    lane_mask;
    logic [BURST_W-1:0]  next_cnt;
    logic [BURST_W-1:0]  burst_lo;
    logic [ARRAY_AW-1:0] idx;
    logic                access;
    logic                begin_burst;
    logic                desel;
    ssac_cyc_t           cyc_nxt;
    logic [WORD_W-1:0]   cur_word;
    logic [WORD_W-1:0]   new_word;
    logic [WORD_W-1:0]   wr_word;
    logic                drive_ok;

    always_comb begin
        sel_ok     = ~chip_select_1_n & chip_select_2 & ~chip_select_3_n;
        write_term = ~global_write_n
                   | (~byte_write_enable_n & ~(&lane_write_n));
        // Global write covers every lane; otherwise only low lane inputs
        if (!global_write_n) begin
            lane_mask = {LANES{1'b1}};
        end else if (!byte_write_enable_n) begin
            lane_mask = ~lane_write_n;
        end else begin
            lane_mask = '0;
        end
        // Bad selects only matter with a strobe low
        desel = (chip_select_1_n & ~controller_addr_strobe_n)
              | (~chip_select_1_n & ~sel_ok
                 & (~processor_addr_strobe_n
                    | ~controller_addr_strobe_n));
    end

    // Cycle decode, highest priority first
    always_comb begin
        access      = 1'b0;
        begin_burst = 1'b0;
        next_cnt    = st_r.cnt;
        if (sleep_request) begin
            cyc_nxt = CYC_SLEEP;
        end else if (desel) begin
            cyc_nxt = CYC_DESEL;
        end else if (!processor_addr_strobe_n && !chip_select_1_n) begin
            // Write inputs are ignored on this edge
            access      = 1'b1;
            begin_burst = 1'b1;
            cyc_nxt     = CYC_READ;
        end else if (!controller_addr_strobe_n) begin
            access      = 1'b1;
            begin_burst = 1'b1;
            cyc_nxt     = write_term ? CYC_WRITE : CYC_READ;
        end else begin
            access = 1'b1;
            if (!burst_step_n) begin
                next_cnt = st_r.cnt + 2'h1;
            end
            // A write here is also the second edge of a processor-strobe write
            cyc_nxt = write_term ? CYC_WRITE : CYC_READ;
        end
    end

    // Burst address; a new burst uses the external address directly
    always_comb begin
        if (st_r.linear) begin
            burst_lo = st_r.base_lo + next_cnt;
        end else begin
            burst_lo = st_r.base_lo ^ next_cnt;
        end
        if (begin_burst) begin
            idx = addr[ARRAY_AW-1:0];
        end else begin
            idx = {st_r.base_hi, burst_lo};
        end
    end

    // Read and merge share one array port
    always_comb begin
        cur_word = st_r.mem[idx];
        for (int i = 0; i < LANES; i++) begin
            new_word[i*LANE_W +: LANE_W] =
                {parity_in[i], dq_in[i*BYTE_W +: BYTE_W]};
        end
    end

    // One merge cell per lane; unselected lanes keep their old bits
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        ssac_lane_merge #(
            .W (LANE_W)
        ) u_merge (
            .old_lane (cur_word[g*LANE_W +: LANE_W]),
            .new_lane (new_word[g*LANE_W +: LANE_W]),
            .wr_en    (lane_mask[g]),
            .merged   (wr_word[g*LANE_W +: LANE_W])
        );
    end

    // The array is written only through the merged word
    always_comb begin
        st_nxt      = st_r;
        st_nxt.kind = cyc_nxt;

        // Output register stage; fresh access after deselect is held off
        st_nxt.q       = st_r.sel_data;
        st_nxt.q_valid = (st_r.kind == CYC_READ);

        if (begin_burst) begin
            st_nxt.base_hi = addr[ARRAY_AW-1:BURST_W];
            st_nxt.base_lo = addr[BURST_W-1:0];
            st_nxt.cnt     = '0;
        end else begin
            st_nxt.cnt = next_cnt;
        end

        if (access && cyc_nxt == CYC_READ) begin
            st_nxt.sel_data = cur_word;
        end
        if (access && cyc_nxt == CYC_WRITE) begin
            // Mask and data taken on the same edge, then committed at once
            st_nxt.mem[idx] = wr_word;
        end

        // AXI write: address and data taken in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = RESP_OKAY;
            case (st_r.aw_addr)
                CTRL_OFS: begin
                    if (st_r.w_strb[0]) begin
                        st_nxt.linear = st_r.w_data[CTRL_LINEAR_BIT];
                    end
                end
                // Status is read-only; a write is answered and dropped
                STATUS_OFS: begin
                    st_nxt.bresp = RESP_OKAY;
                end
                default: begin
                    st_nxt.bresp = RESP_SLVERR;
                end
            endcase
        end
        // Readies drop while an item waits for its partner
        st_nxt.awready = ~st_nxt.aw_have;
        st_nxt.wready  = ~st_nxt.w_have;

        // AXI read
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = '0;
            st_nxt.rresp  = RESP_OKAY;
            case (s_axi_araddr)
                CTRL_OFS: begin
                    st_nxt.rdata[CTRL_LINEAR_BIT] = st_r.linear;
                end
                STATUS_OFS: begin
                    st_nxt.rdata[STAT_KIND_LSB +: 2] = st_r.kind;
                    st_nxt.rdata[STAT_LO_LSB +: BURST_W] = st_r.base_lo;
                    st_nxt.rdata[STAT_CNT_LSB +: BURST_W] = st_r.cnt;
                    st_nxt.rdata[STAT_QVAL_BIT] = st_r.q_valid;
                    st_nxt.rdata[STAT_SLEEP_BIT] = (st_r.kind == CYC_SLEEP);
                end
                default: begin
                    st_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
        // One read in flight; a new address waits for rready
        st_nxt.arready = ~st_nxt.rvalid;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Output enable must react without the clock, so it is gated here
    always_comb begin
        // Write cycles carry kind WRITE, so drive stays off there
        drive_ok  = st_r.q_valid && (st_r.kind == CYC_READ);
        dq_oe     = drive_ok && !output_drive_n
                    && !sleep_request;
        parity_oe = dq_oe;
    end

    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            dq_out[i*BYTE_W +: BYTE_W] = st_r.q[i*LANE_W +: BYTE_W];
            parity_out[i]              = st_r.q[i*LANE_W + BYTE_W];
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;

endmodule // ssac_top

// Lane write merge; one cell per byte lane
module ssac_lane_merge #(
    parameter int W = ssac_pkg::LANE_W
) (
    // Stored and incoming lane
    input  wire logic [W-1:0] old_lane,
    input  wire logic [W-1:0] new_lane,
    // Lane write enable
    input  wire logic         wr_en,
    // Lane to store
    output logic      [W-1:0] merged
);
    import ssac_pkg::*;

    always_comb begin
        merged = wr_en ? new_lane : old_lane;
    end

endmodule // ssac_lane_merge

// ==== ssac_props.sv ====
`timescale 1ns/1ps
module ssac_props
    import ssac_pkg::*;
(
    // Clock and reset
    input logic             clock,
    input logic             rstn,
    // Bus controls
    input logic             chip_select_1_n,
    input logic             chip_select_2,
    input logic             chip_select_3_n,
    input logic             sleep_request,
    input logic             processor_addr_strobe_n,
    input logic             controller_addr_strobe_n,
    input logic             global_write_n,
    input logic             byte_write_enable_n,
    input logic [LANES-1:0] lane_write_n,
    input logic             output_drive_n,
    // Pin enables
    input logic             dq_oe,
    input logic             parity_oe
);
    wire ok = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
    wire wt = !global_write_n || (!byte_write_enable_n && !(&lane_write_n));
    wire ps = !processor_addr_strobe_n;
    wire cs = !controller_addr_strobe_n;
    wire dsl = !sleep_request && ((chip_select_1_n && cs)
        || (!chip_select_1_n && !ok && (ps || cs)));
    wire rb = !sleep_request && ok && ps;
    wire cw = !sleep_request && ok && !ps && cs && wt;
    wire ct = !sleep_request && !cs && (!ps || chip_select_1_n);

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_sleep; sleep_request |-> !dq_oe && !parity_oe; endproperty
    a_sleep: assert property (p_sleep) else $error("drive in sleep");
    property p_odn; output_drive_n |-> !dq_oe; endproperty
    a_odn: assert property (p_odn) else $error("drive with oe high");
    property p_pair; dq_oe == parity_oe; endproperty
    a_pair: assert property (p_pair) else $error("enables differ");
    property p_desel; dsl |=> !dq_oe; endproperty
    a_desel: assert property (p_desel) else $error("drive after desel");
    property p_cw; cw |=> !dq_oe; endproperty
    a_cw: assert property (p_cw) else $error("drive in write");
    property p_ctw; ct && wt |=> !dq_oe; endproperty
    a_ctw: assert property (p_ctw) else $error("drive in burst write");
    property p_first; dsl ##1 rb |=> !dq_oe; endproperty
    a_first: assert property (p_first) else $error("first cycle drive");
    property p_rd;
        rb ##1 (ct && !wt) |=> dq_oe == (!output_drive_n && !sleep_request);
    endproperty
    a_rd: assert property (p_rd) else $error("read enable wrong");
endmodule // ssac_props

bind ssac_top ssac_props u_props (.*);

// ==== ssac_host.sv ====
`timescale 1ns/1ps
module ssac_host
    import ssac_pkg::*;
(
    // Clock
    input  logic              clock,
    // Controls toward the memory
    output logic [ADDR_W-1:0] addr,
    output logic              sleep_request,
    output logic              chip_select_1_n,
    output logic              chip_select_2,
    output logic              chip_select_3_n,
    output logic              processor_addr_strobe_n,
    output logic              controller_addr_strobe_n,
    output logic              burst_step_n,
    output logic              global_write_n,
    output logic              byte_write_enable_n,
    output logic [LANES-1:0]  lane_write_n,
    output logic              output_drive_n,
    // Write data
    output logic [DATA_W-1:0] dq_in,
    output logic [LANES-1:0]  parity_in
);
    initial {addr, sleep_request, chip_select_1_n, chip_select_2,
        chip_select_3_n, processor_addr_strobe_n, controller_addr_strobe_n,
        burst_step_n, global_write_n, byte_write_enable_n, lane_write_n,
        output_drive_n, dq_in, parity_in} = '1;

    function automatic logic wt(input logic [5:0] w);
        return !w[5] || (!w[4] && !(&w[3:0]));
    endfunction

    // Kinds: 0 processor strobe, 1 controller strobe, 2 step, 3 hold,
    // 4 deselect, 5 sleep
    task automatic op(input int k, input logic [ADDR_W-1:0] a,
                      input logic [WORD_W-1:0] d, input logic [5:0] w,
                      input logic od);
        @(posedge clock);
        sleep_request <= (k == 5);
        chip_select_1_n <= 1'h0;
        chip_select_2 <= (k != 4);
        chip_select_3_n <= 1'h0;
        processor_addr_strobe_n <= !(k == 0 || k == 4);
        controller_addr_strobe_n <= (k != 1);
        burst_step_n <= (k != 2);
        {global_write_n, byte_write_enable_n, lane_write_n} <= w;
        addr <= a;
        // Idle data toggles so stale values cannot slip through
        {parity_in, dq_in} <= wt(w) ? d : ~{parity_in, dq_in};
        output_drive_n <= wt(w) ? 1'h1 : od;
    endtask
endmodule // ssac_host

// ==== ssac_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module testbench
    import ssac_pkg::*;
;
    logic clock = 1'h0, rstn = 1'h0, sleep_request, chip_select_1_n,
        chip_select_2, chip_select_3_n, processor_addr_strobe_n,
        controller_addr_strobe_n, burst_step_n, global_write_n,
        byte_write_enable_n, output_drive_n, dq_oe, parity_oe,
        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0,
        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [ADDR_W-1:0] addr, ad;
    logic [LANES-1:0]  lane_write_n, parity_in, parity_out;
    logic [DATA_W-1:0] dq_in, dq_out;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0,
        s_axi_araddr = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, cnt;
    logic [WORD_W-1:0] mem [DEPTH], dd, qd [2];
    logic [5:0]  base;
    logic        lin, qv [2];
    int seed, err_count, compares, cycles;

    ssac_top  DUT  (.*);
    ssac_host host (.*);

    always #4 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles > 5000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test;
        if (err_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic axw(input logic [31:0] a, d, input logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        `CHK(s_axi_bresp, r)
    endtask

    task automatic axr(input logic [31:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask

    // One bus edge; the model keeps a two-deep queue of expected read words
    task automatic go(input int k, input logic [5:0] w);
        logic [5:0] ix;
        logic       wr;
        if (k <= 1) {base, cnt} = {ad[5:0], 2'h0};
        if (k == 2) cnt++;
        ix = {base[5:2], lin ? base[1:0] + cnt : base[1:0] ^ cnt};
        wr = k inside {[1:3]} && host.wt(w);
        for (int i = 0; i < LANES; i++)
            if (wr && (!w[5] || !w[i])) begin
                mem[ix][8*i +: 8] = dd[8*i +: 8];
                mem[ix][32+i] = dd[32+i];
            end
        host.op(k, ad, dd, w, 1'($random(seed)));
        #1;
        if (qv[1] && qv[0]) `CHK({parity_out, dq_out}, qd[1])
        {qv[1], qd[1]} = {qv[0], qd[0]};
        {qv[0], qd[0]} = {k < 4 && !wr, mem[ix]};
    endtask

    initial begin
        seed = 64109;
        foreach (mem[i]) mem[i] = 36'h0;
        repeat (4) @(posedge clock);
        rstn <= 1'h1;
        for (int m = 0; m < 2; m++) begin
            lin = 1'(m);
            if (m == 1) axw(CTRL_OFS, 32'h1, RESP_OKAY);
            axr(CTRL_OFS);
            `CHK(rd[0], lin)
            repeat (3) begin
                ad = 19'($random(seed));
                dd = {4'($random(seed)), 32'($random(seed))};
                go(4, 6'h3F);
                go(1, 6'h1F);
                repeat (3) begin
                    dd = {4'($random(seed)), 32'($random(seed))};
                    go(2, {2'h2, 4'($random(seed))});
                end
                go(4, 6'h3F);
                go(0, 6'h1F);
                repeat (3) go(2, 6'h2F);
                go(3, 6'h3F);
                go(1, 6'h3F);
                go(3, 6'h3F);
                go(0, 6'h3F);
                dd = {4'($random(seed)), 32'($random(seed))};
                go(3, 6'h1F);
                repeat (2) go(3, 6'h3F);
                repeat (2) go(4, 6'h3F);
            end
        end
        go(5, 6'h1F);
        axr(STATUS_OFS);
        `CHK({rd[7], rd[1:0]}, 3'h7)
        axw(STATUS_OFS, 32'h0, RESP_OKAY);
        axw(32'h10, 32'h0, RESP_SLVERR);
        axr(32'h8);
        `CHK(rr, RESP_SLVERR)
        stop_test();
    end
endmodule // testbench
